/* File: verilog/rssc_pkg.sv */
// Package with constants and types for the run/stop sequence control block.
package rssc_pkg;

  // Access codes written by the operator.
  localparam logic [3:0] RSSC_CODE_UNLOCK = 4'h3;
  localparam logic [3:0] RSSC_CODE_RESET3 = 4'h9;
  localparam logic [3:0] RSSC_CODE_DONE   = 4'h1;
  localparam logic [3:0] RSSC_CODE_RST_VAL = 4'h1;

  // Debounce time in ns and the derived cycle count at 250 MHz.
  localparam int RSSC_CLK_MHZ      = 250;
  localparam int RSSC_DEB_NS       = 1000;
  localparam int RSSC_DEB_CYC      = (RSSC_DEB_NS * RSSC_CLK_MHZ + 999) / 1000;

  // Reference scaling: full-scale code maps to full frequency.
  localparam int RSSC_REF_W        = 12;
  localparam int RSSC_FREQ_W       = 16;
  localparam logic [RSSC_FREQ_W-1:0] RSSC_FULL_FREQ = 16'h1770;

  // Contact inputs, index order used by the debouncer.
  localparam int RSSC_N_IN = 6;
  localparam int RSSC_IN_RUN  = 0;
  localparam int RSSC_IN_STOP = 1;
  localparam int RSSC_IN_DIR  = 2;
  localparam int RSSC_IN_FWD  = 3;
  localparam int RSSC_IN_REV  = 4;
  localparam int RSSC_IN_LR   = 5;

  // Keypad key group.
  typedef struct packed {
    logic run_key;
    logic stop_key;
    logic direction_key;
    logic local_remote_key;
  } rssc_keys_t;

  // Drive command group.
  typedef struct packed {
    logic run;
    logic reverse;
    logic ext_fault;
  } rssc_cmd_t;

  // Sequence states.
  typedef enum logic [2:0] {
    RSSC_ST_STOP  = 3'b001,
    RSSC_ST_RUN   = 3'b010,
    RSSC_ST_FAULT = 3'b100
  } rssc_state_t;

endpackage

/* File: verilog/rssc_seq.sv */
// Run/stop and direction sequencing for terminal and keypad control.
`timescale 1ns/1ps

// Contract
// - Three-wire run closure sets run latch.
// - Run ignored while stop contact open.
// - Stop opening clears latch and stops.
// - Direction open forward, closed reverse.
// - Direction change accepted while running.
// - Power loss clears the run latch.
// - Two-wire runs only while input held.
// - Code 9 restores defaults, reads 1.
// - Code 3 unlocks all parameters.
// - Reference lamp off keypad, on analog.
// - Sequence lamp off keypad, on terminals.
// - Local key selects keypad for both.
// - Keypad run, stop, direction keys act.
// - Voltage reference scales linearly to frequency.
// - Power-up sources both from terminals.
// - Both two-wire inputs: stop, external fault.
module rssc_seq
  import rssc_pkg::*;
#(
  parameter int DEB_CYC = RSSC_DEB_CYC
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   three_wire_mode_i,
  input  wire logic                   run_pushbutton_i,
  input  wire logic                   stop_pushbutton_i,
  input  wire logic                   direction_switch_i,
  input  wire logic                   forward_run_contact_i,
  input  wire logic                   reverse_run_contact_i,
  input  wire rssc_keys_t             keys_i,
  input  wire logic                   ref_use_current_i,
  input  wire logic [RSSC_REF_W-1:0]  voltage_reference_input_i,
  input  wire logic [RSSC_REF_W-1:0]  current_reference_input_i,
  input  wire logic [RSSC_FREQ_W-1:0] keypad_freq_i,
  input  wire logic                   code_wr_i,
  input  wire logic [3:0]             code_wdata_i,
  output rssc_cmd_t                   cmd_o,
  output logic [RSSC_FREQ_W-1:0]      freq_ref_o,
  output logic                        sequence_source_lamp_o,
  output logic                        reference_source_lamp_o,
  output logic [3:0]                  access_code_parameter_o,
  output logic                        unlocked_o,
  output logic                        factory_reset_o
);

  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] DEB_MAX = CW'(DEB_CYC);

  // Two-flop synchronisers and debounce counters per contact input.
  logic [RSSC_N_IN-1:0] raw;
  logic [RSSC_N_IN-1:0] sync1_r;
  logic [RSSC_N_IN-1:0] sync2_r;
  logic [RSSC_N_IN-1:0] deb_r;
  logic [RSSC_N_IN-1:0] deb_nxt;
  logic                 lr_prev_r;

  assign raw = {keys_i.local_remote_key, reverse_run_contact_i, forward_run_contact_i,
                direction_switch_i, stop_pushbutton_i, run_pushbutton_i};

  genvar g;
  generate
    for (g = 0; g < RSSC_N_IN; g++) begin : g_deb
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;
      // Count while the synchronised level differs from the accepted one.
      always_comb begin
        cnt_nxt    = '0;
        deb_nxt[g] = deb_r[g];
        if (sync2_r[g] != deb_r[g]) begin
          if (cnt_r == DEB_MAX) begin
            deb_nxt[g] = sync2_r[g];
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  // Synchroniser and debounced levels; all reset to zero, so the stop contact reads open after reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      deb_r     <= '0;
      lr_prev_r <= 1'b0;
    end else begin
      sync1_r   <= raw;
      sync2_r   <= sync1_r;
      deb_r     <= deb_nxt;
      lr_prev_r <= deb_r[RSSC_IN_LR];
    end
  end

  logic run_c, stop_c, dir_c, fwd_c, rev_c, lr_edge;
  assign run_c   = deb_r[RSSC_IN_RUN];
  assign stop_c  = deb_r[RSSC_IN_STOP];
  assign dir_c   = deb_r[RSSC_IN_DIR];
  assign fwd_c   = deb_r[RSSC_IN_FWD];
  assign rev_c   = deb_r[RSSC_IN_REV];
  assign lr_edge = deb_r[RSSC_IN_LR] & ~lr_prev_r;

  // Source selection: terminals after reset, keypad after the local key.
  logic local_r, local_nxt;
  always_comb begin
    local_nxt = local_r;
    if (lr_edge) begin
      local_nxt = ~local_r;
    end
  end

  // Sequence state machine and direction.
  rssc_state_t st_r, st_nxt;
  logic        kdir_r, kdir_nxt;
  logic        rev_r, rev_nxt;
  always_comb begin
    st_nxt   = st_r;
    kdir_nxt = kdir_r;
    rev_nxt  = rev_r;
    if (keys_i.direction_key && local_r) begin
      kdir_nxt = ~kdir_r;
    end
    if (local_r) begin
      rev_nxt = kdir_r;
      case (st_r)
        RSSC_ST_RUN: if (keys_i.stop_key) st_nxt = RSSC_ST_STOP;
        default: begin
          st_nxt = RSSC_ST_STOP;
          if (keys_i.run_key && !keys_i.stop_key) st_nxt = RSSC_ST_RUN;
        end
      endcase
    end else if (three_wire_mode_i) begin
      rev_nxt = dir_c;
      case (st_r)
        RSSC_ST_RUN: if (!stop_c) st_nxt = RSSC_ST_STOP;
        default: begin
          st_nxt = RSSC_ST_STOP;
          if (run_c && stop_c) st_nxt = RSSC_ST_RUN;
        end
      endcase
    end else begin
      if (fwd_c && rev_c) begin
        st_nxt = RSSC_ST_FAULT;
      end else if (fwd_c || rev_c) begin
        st_nxt  = RSSC_ST_RUN;
        rev_nxt = rev_c;
      end else begin
        st_nxt = RSSC_ST_STOP;
      end
    end
  end

  // Access code parameter; a reset request reads back as done.
  logic [3:0] code_r, code_nxt;
  logic       unl_r, unl_nxt, frst_r, frst_nxt;
  always_comb begin
    code_nxt = code_r;
    unl_nxt  = unl_r;
    frst_nxt = 1'b0;
    if (code_wr_i) begin
      if (code_wdata_i == RSSC_CODE_RESET3) begin
        code_nxt = RSSC_CODE_DONE;
        unl_nxt  = 1'b0;
        frst_nxt = 1'b1;
      end else begin
        code_nxt = code_wdata_i;
        unl_nxt  = (code_wdata_i == RSSC_CODE_UNLOCK);
      end
    end
  end

  // Linear reference scaling, zero maps to zero, full scale to full frequency.
  // Dividing by the full-scale code instead of shifting makes the top code exact.
  localparam int            PW       = RSSC_REF_W + RSSC_FREQ_W;
  localparam logic [PW-1:0] REF_MAX  = PW'({RSSC_REF_W{1'b1}});
  localparam logic [PW-1:0] REF_HALF = REF_MAX >> 1;
  logic [RSSC_REF_W-1:0]             ana;
  logic [PW-1:0]                     prod;
  logic [PW-1:0]                     quot;
  logic [RSSC_FREQ_W-1:0]            freq_nxt;
  assign ana  = ref_use_current_i ? current_reference_input_i : voltage_reference_input_i;
  assign prod = ana * RSSC_FULL_FREQ;
  assign quot = (prod + REF_HALF) / REF_MAX;
  assign freq_nxt = local_r ? keypad_freq_i : quot[RSSC_FREQ_W-1:0];

  // Drive command, registered beside the state so the outputs come from flops.
  rssc_cmd_t cmd_r, cmd_nxt;
  always_comb begin
    cmd_nxt.run       = (st_nxt == RSSC_ST_RUN);
    cmd_nxt.reverse   = rev_nxt;
    cmd_nxt.ext_fault = (st_nxt == RSSC_ST_FAULT);
  end

  // Registers; reset models power loss and clears the run latch.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r                    <= RSSC_ST_STOP;
      cmd_r                   <= '0;
      local_r                 <= 1'b0;
      kdir_r                  <= 1'b0;
      rev_r                   <= 1'b0;
      code_r                  <= RSSC_CODE_RST_VAL;
      unl_r                   <= 1'b0;
      frst_r                  <= 1'b0;
      freq_ref_o              <= '0;
      sequence_source_lamp_o  <= 1'b1;
      reference_source_lamp_o <= 1'b1;
    end else begin
      st_r                    <= st_nxt;
      cmd_r                   <= cmd_nxt;
      local_r                 <= local_nxt;
      kdir_r                  <= kdir_nxt;
      rev_r                   <= rev_nxt;
      code_r                  <= code_nxt;
      unl_r                   <= unl_nxt;
      frst_r                  <= frst_nxt;
      freq_ref_o              <= freq_nxt;
      sequence_source_lamp_o  <= ~local_nxt;
      reference_source_lamp_o <= ~local_nxt;
    end
  end

  assign cmd_o                   = cmd_r;
  assign access_code_parameter_o = code_r;
  assign unlocked_o              = unl_r;
  assign factory_reset_o         = frst_r;

  // Three-wire: stop open while running ends the run next cycle.
  property p_stop_clears;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!local_r && three_wire_mode_i && st_r == RSSC_ST_RUN && !stop_c) |=> !cmd_o.run;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("Run held.");

  property p_no_run_stop_open;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!local_r && three_wire_mode_i && !cmd_o.run && !stop_c) |=> !cmd_o.run;
  endproperty
  a_no_run_stop_open: assert property (p_no_run_stop_open) else $error("Run taken.");

  sequence s_run_press;
    !local_r && three_wire_mode_i && run_c && stop_c;
  endsequence
  property p_latch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_run_press |=> cmd_o.run;
  endproperty
  a_latch: assert property (p_latch) else $error("Run press not latched.");

  property p_dir;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!local_r && three_wire_mode_i) |=> (cmd_o.reverse == $past(dir_c));
  endproperty
  a_dir: assert property (p_dir) else $error("Direction mismatch.");

  property p_two_wire;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!local_r && !three_wire_mode_i && !fwd_c && !rev_c) |=> !cmd_o.run;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("Run without held input.");

  property p_fault;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!local_r && !three_wire_mode_i && fwd_c && rev_c) |=> (cmd_o.ext_fault && !cmd_o.run);
  endproperty
  a_fault: assert property (p_fault) else $error("Both inputs without fault.");

  property p_code9;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (code_wr_i && code_wdata_i == RSSC_CODE_RESET3) |=>
        (access_code_parameter_o == RSSC_CODE_DONE && factory_reset_o);
  endproperty
  a_code9: assert property (p_code9) else $error("Factory reset wrong.");

  property p_code3;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (code_wr_i && code_wdata_i == RSSC_CODE_UNLOCK) |=> unlocked_o;
  endproperty
  a_code3: assert property (p_code3) else $error("Unlock failed.");

  property p_lamps;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (sequence_source_lamp_o == !local_r) && (reference_source_lamp_o == !local_r);
  endproperty
  a_lamps: assert property (p_lamps) else $error("Lamp wrong.");

  // Keypad control hands the keypad frequency straight through.
  property p_local_freq;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      local_r |=> (freq_ref_o == $past(keypad_freq_i));
  endproperty
  a_local_freq: assert property (p_local_freq) else $error("Keypad frequency lost.");

  // The keypad stop key always ends a run under keypad control.
  property p_key_stop;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (local_r && keys_i.stop_key) |=> !cmd_o.run;
  endproperty
  a_key_stop: assert property (p_key_stop) else $error("Keypad stop ignored.");

endmodule

/* File: test/rssc_operator.sv */
// Operator model that works the run and stop pushbuttons of the terminal strip.
`timescale 1ns/1ps
module rssc_operator #(
  parameter int HOLD = 8
) (
  input  wire logic clk_i,
  input  wire logic press_run_i,
  input  wire logic tap_stop_i,
  input  wire logic stop_open_i,
  output logic      run_pushbutton_o,
  output logic      stop_pushbutton_o
);
  int run_cnt = 0;
  int stop_cnt = 0;
  // A request starts a momentary press that lets go after HOLD cycles.
  always @(posedge clk_i) begin
    run_cnt <= press_run_i ? HOLD : (run_cnt > 0 ? run_cnt - 1 : 0);
    stop_cnt <= tap_stop_i ? HOLD : (stop_cnt > 0 ? stop_cnt - 1 : 0);
  end
  // The stop contact is normally closed, so it reads high unless opened.
  assign run_pushbutton_o = run_cnt != 0;
  assign stop_pushbutton_o = !(stop_cnt != 0 || stop_open_i);
endmodule

/* File: test/rssc_seq_bench.sv */
// Self-checking bench for the run/stop sequence control block.
`timescale 1ns/1ps
module rssc_seq_bench;
  import rssc_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, mode3 = 1, dir = 0, fwd = 0, rev = 0;
  logic press = 0, tap = 0, hold_open = 0, wr = 0, use_cur = 0, run_pb, stop_pb;
  logic [3:0] wdata = 4'h0;
  logic [11:0] vref = 12'h000, iref = 12'h000;
  logic [15:0] kfreq = 16'h0000, freq;
  rssc_keys_t keys = '0;
  rssc_cmd_t cmd;
  logic seq_lamp, ref_lamp, unl, fr, smp = 0;
  logic [3:0] code;
  logic [26:0] e_m = '1, qe[$], qm[$];
  logic e_run = 0, e_rev = 0, e_flt = 0, e_lamp = 1, e_unl = 0, e_fr = 0;
  logic [3:0] e_code = 4'h1;
  logic [15:0] e_freq = 16'h0000;
  int mismatches = 0, cmp_count = 0, cycles = 0;

  rssc_operator #(.HOLD(8)) op (.clk_i(clk_sys_i), .press_run_i(press), .tap_stop_i(tap),
    .stop_open_i(hold_open), .run_pushbutton_o(run_pb), .stop_pushbutton_o(stop_pb));
  rssc_seq #(.DEB_CYC(2)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .three_wire_mode_i(mode3), .run_pushbutton_i(run_pb), .stop_pushbutton_i(stop_pb),
    .direction_switch_i(dir), .forward_run_contact_i(fwd), .reverse_run_contact_i(rev),
    .keys_i(keys), .ref_use_current_i(use_cur), .voltage_reference_input_i(vref),
    .current_reference_input_i(iref), .keypad_freq_i(kfreq), .code_wr_i(wr),
    .code_wdata_i(wdata), .cmd_o(cmd), .freq_ref_o(freq), .sequence_source_lamp_o(seq_lamp),
    .reference_source_lamp_o(ref_lamp), .access_code_parameter_o(code), .unlocked_o(unl),
    .factory_reset_o(fr));

  // Clock at 250 MHz.
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Reports a mismatch between a seen and an expected value.
  task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Waits n edges and lands just after the last one.
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask

  // Notes the expected outputs; the monitor compares them at the next edge.
  task automatic note();
    qe.push_back({e_run, e_rev, e_flt, e_lamp, e_lamp, e_code, e_unl, e_fr, e_freq});
    qm.push_back(e_m);
    smp = 1;
    cyc(1);
    smp = 0;
  endtask

  // Expected frequency for a reference code: full-scale code gives full frequency, rounded.
  function automatic logic [15:0] fexp(input logic [11:0] c);
    return 16'((32'(c) * 32'(RSSC_FULL_FREQ) + 32'h7ff) / 32'hfff);
  endfunction

  task automatic pwr_cycle();
    rst_n_i = 0;
    cyc(2);
    rst_n_i = 1;
    cyc(12);
  endtask

  // Monitor: pops the oldest note whenever a result is due and compares it.
  always @(posedge clk_sys_i) begin
    if (smp) begin
      logic [26:0] m;
      m = qm.pop_front();
      chk({cmd, seq_lamp, ref_lamp, code, unl, fr, freq} & m, qe.pop_front() & m);
    end
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    void'($urandom(32'hfcc2));
    vref = 12'($urandom());
    kfreq = 16'($urandom());
    cyc(8);
    rst_n_i = 1;
    cyc(12);
    e_freq = fexp(vref);
    note();
    hold_open = 1; press = 1; cyc(1); press = 0; cyc(14);
    note();
    hold_open = 0; cyc(10); press = 1; cyc(1); press = 0; cyc(14);
    e_run = 1; note();
    dir = 1; cyc(12); e_rev = 1; note();
    dir = 0; cyc(12); e_rev = 0; note();
    hold_open = 1; cyc(1); hold_open = 0; cyc(10); note();
    tap = 1; cyc(1); tap = 0; cyc(14);
    e_run = 0; note();
    for (int i = 0; i < 6; i++) begin
      vref = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom());
      cyc(3); e_freq = (i == 1) ? RSSC_FULL_FREQ : fexp(vref); note();
    end
    use_cur = 1; iref = 12'($urandom()); cyc(3); e_freq = fexp(iref); note();
    use_cur = 0;
    keys.local_remote_key = 1; cyc(10); keys.local_remote_key = 0; cyc(6);
    e_lamp = 0; e_freq = kfreq; note();
    keys.run_key = 1; cyc(1); keys.run_key = 0; cyc(3);
    e_run = 1; note();
    keys.direction_key = 1; cyc(1); keys.direction_key = 0; cyc(3);
    e_rev = 1; note();
    keys.stop_key = 1; cyc(1); keys.stop_key = 0; cyc(3);
    e_run = 0; note();
    pwr_cycle(); e_lamp = 1; e_rev = 0; e_freq = fexp(vref); note();
    press = 1; cyc(1); press = 0; cyc(14); e_run = 1; note();
    pwr_cycle(); e_run = 0; note();
    mode3 = 0; fwd = 1; cyc(12); e_run = 1; note();
    fwd = 0; cyc(12); e_run = 0; note();
    rev = 1; cyc(12); e_run = 1; e_rev = 1; note();
    fwd = 1; cyc(12); e_run = 0; e_flt = 1; e_m[25] = 0; note();
    fwd = 0; rev = 0; e_m = '1; pwr_cycle();
    e_run = 0; e_rev = 0; e_flt = 0;
    wr = 1; wdata = 4'h3; cyc(1); wr = 0;
    e_code = 4'h3; e_unl = 1; note();
    wr = 1; wdata = 4'h9; cyc(1); wr = 0;
    e_code = 4'h1; e_unl = 0; e_fr = 1; note();
    e_fr = 0; cyc(1); note();
    cyc(2);
    results();
  end
endmodule
